//--- src/dti_monitor.sv
// Dual-channel torque inhibit monitor: run enable, trip, status and fault latch
//
// Summary of operation
// RULE1: A low channel input inhibits torque and blocks running.
// RULE2: Run enable releases only when both filtered channels are high.
// RULE3: Status output on only when both channels are low.
// RULE4: Both low: drive held off and inhibit trip reported.
// RULE5: Channels disagree: block start, report trip, status off.
// RULE6: Disagreement beyond detection time latches a locked fault, inhibiting regardless.
// RULE7: Mismatch below 1.6 s never faults, above 3.0 s always; trip at 2.3 s.
// RULE8: Locked fault clears only by power cycle, here the reset.
// RULE9: Status keeps tracking inputs on auxiliary supply alone.
// RULE10: Low test pulses narrower than 2 ms are ignored.
// RULE11: Controller holds a channel low about 6 ms to expect a reaction.
// RULE12: Mismatch timer and pulse filter are counters; mismatch timer restarts on agreement.
// RULE13: Out of reset run enable is low, fault cleared, inputs then evaluated.
`timescale 1ns/1ps
module dti_monitor (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic inhibit_channel_a_in,
  input  wire logic inhibit_channel_b_in,
  output logic      run_enable_out,
  output logic      inhibit_trip_out,
  output logic      inhibit_status_out,
  output logic      fault_locked_out,
  output logic [1:0] state_out
);
  // ****************************************
  // Input filtering
  // ****************************************
  logic chan_a;
  logic chan_b;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic filt_q;
      dti_pulse_filter u_filt (                                     // RULE10 RULE12
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .raw_in     ((gi == 0) ? inhibit_channel_a_in : inhibit_channel_b_in),
        .filt_out   (filt_q)
      );
    end
  endgenerate

  assign chan_a = g_filt[0].filt_q;
  assign chan_b = g_filt[1].filt_q;

  // ****************************************
  // Classification and mismatch timer
  // ****************************************
  localparam logic [dti_pkg::MISM_W-1:0] MISM_LIMIT = dti_pkg::MISM_W'(dti_pkg::MISMATCH_CYCLES);

  wire both_high = chan_a & chan_b;                                 // RULE2
  wire both_low  = ~chan_a & ~chan_b;                               // RULE1
  wire disagree  = chan_a ^ chan_b;                                 // RULE5

  dti_pkg::dti_state_e            state;
  dti_pkg::dti_state_e            next_state;
  logic [dti_pkg::MISM_W-1:0]     mism_count;
  logic [dti_pkg::MISM_W-1:0]     next_mism_count;

  // Count restarts whenever channels agree; saturation is moot once locked
  assign next_mism_count = (disagree && state != dti_pkg::DTI_LOCKED) ? mism_count + 1'b1 : '0;  // RULE12
  wire   mism_expired    = disagree && (mism_count >= MISM_LIMIT - 1'b1);                        // RULE7

  always_comb begin
    case (state)
      dti_pkg::DTI_LOCKED: next_state = dti_pkg::DTI_LOCKED;       // RULE8
      dti_pkg::DTI_SAFE,
      dti_pkg::DTI_RUN,
      dti_pkg::DTI_MISMATCH: begin
        if (mism_expired) begin
          next_state = dti_pkg::DTI_LOCKED;                        // RULE6
        end else if (disagree) begin
          next_state = dti_pkg::DTI_MISMATCH;
        end else if (both_high) begin
          next_state = dti_pkg::DTI_RUN;
        end else begin
          next_state = dti_pkg::DTI_SAFE;
        end
      end
      default: next_state = dti_pkg::DTI_LOCKED;
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic next_run;
  logic next_trip;
  logic next_status;

  assign next_run    = (next_state == dti_pkg::DTI_RUN);           // RULE1 RULE2 RULE6
  assign next_trip   = ~next_run;                                  // RULE4 RULE5
  // Status follows inputs except in DTI_LOCKED, where it stays off; no dependence on main power, only on the logic supply
  assign next_status = (next_state == dti_pkg::DTI_SAFE);          // RULE3 RULE9

  // Reset stands for full power removal, the only way out of the lock
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state              <= dti_pkg::DTI_SAFE;                     // RULE13
      mism_count         <= '0;
      run_enable_out     <= 1'b0;
      inhibit_trip_out   <= 1'b1;
      inhibit_status_out <= 1'b0;
      fault_locked_out   <= 1'b0;
      state_out          <= 2'b00;
    end else begin
      state              <= next_state;
      mism_count         <= next_mism_count;
      run_enable_out     <= next_run;
      inhibit_trip_out   <= next_trip;
      inhibit_status_out <= next_status;
      fault_locked_out   <= (next_state == dti_pkg::DTI_LOCKED);
      state_out          <= next_state;
    end
  end
endmodule

//--- src/dti_pkg.sv
// Constants for the dual-channel torque inhibit monitor
package dti_pkg;
  localparam int unsigned CLK_HZ           = 200_000_000;
  // Pulse filter: lows narrower than 2 ms are ignored
  localparam int unsigned FILT_TIME_US     = 2_000;
  localparam int unsigned FILT_CYCLES      = FILT_TIME_US * (CLK_HZ / 1_000_000);
  // Mismatch detection point, between 1.6 s and 3.0 s, typical 2.3 s
  localparam int unsigned MISMATCH_TIME_MS = 2_300;
  localparam longint unsigned MISMATCH_CYCLES_L = longint'(MISMATCH_TIME_MS) * longint'(CLK_HZ / 1_000);
  localparam int unsigned MISMATCH_CYCLES  = int'(MISMATCH_CYCLES_L);
  localparam int unsigned FILT_W           = 20;
  localparam int unsigned MISM_W           = 30;

  typedef enum logic [1:0] {
    DTI_SAFE     = 2'b00,
    DTI_RUN      = 2'b01,
    DTI_MISMATCH = 2'b10,
    DTI_LOCKED   = 2'b11
  } dti_state_e;
endpackage

//--- src/dti_pulse_filter.sv
// Per-channel filter that ignores short low-going test pulses
`timescale 1ns/1ps
module dti_pulse_filter #(
  parameter logic [dti_pkg::FILT_W-1:0] FILT_CYCLES = dti_pkg::FILT_W'(dti_pkg::FILT_CYCLES)
) (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic raw_in,
  output logic      filt_out
);
  logic [dti_pkg::FILT_W-1:0] low_count;
  logic [dti_pkg::FILT_W-1:0] next_low_count;
  logic                       next_filt;

  // A high input passes at once, so the release path never waits on the filter
  assign next_low_count = raw_in ? '0 : ((low_count == FILT_CYCLES) ? low_count : low_count + 1'b1);
  assign next_filt      = raw_in ? 1'b1 : ((low_count == FILT_CYCLES) ? 1'b0 : filt_out);

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_count <= '0;
      filt_out  <= 1'b0;
    end else begin
      low_count <= next_low_count;
      filt_out  <= next_filt;
    end
  end
endmodule

//--- tb/dti_monitor_checker.sv
// Monitor assertions
`timescale 1ns/1ps
module dti_monitor_checker (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       inhibit_channel_a_in,
  input  wire logic       inhibit_channel_b_in,
  input  wire logic       run_enable_out,
  input  wire logic       inhibit_trip_out,
  input  wire logic       inhibit_status_out,
  input  wire logic       fault_locked_out,
  input  wire logic [1:0] state_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_tr; inhibit_trip_out != run_enable_out; endproperty
  a_tr: assert property (p_tr) else $error("trip");
  property p_run; run_enable_out |-> state_out == 2'b01; endproperty
  a_run: assert property (p_run) else $error("run");
  property p_st; inhibit_status_out |-> state_out == 2'b00; endproperty
  a_st: assert property (p_st) else $error("status");
  property p_mm; state_out == 2'b10 |-> !inhibit_status_out; endproperty
  a_mm: assert property (p_mm) else $error("mismatch");
  property p_mt; state_out == 2'b10 |-> inhibit_trip_out && !run_enable_out; endproperty
  a_mt: assert property (p_mt) else $error("mismatch trip");
  property p_sr; inhibit_status_out |-> !run_enable_out && inhibit_trip_out; endproperty
  a_sr: assert property (p_sr) else $error("status run");
  property p_lk; fault_locked_out |=> fault_locked_out; endproperty
  a_lk: assert property (p_lk) else $error("unlock");
  property p_ls; fault_locked_out |-> state_out == 2'b11; endproperty
  a_ls: assert property (p_ls) else $error("lock");
  property p_rr; $rose(run_enable_out) |-> $past(state_out) != 2'b11; endproperty
  a_rr: assert property (p_rr) else $error("rise");
  property p_up; (inhibit_channel_a_in && inhibit_channel_b_in)[*4] |-> run_enable_out || fault_locked_out; endproperty
  a_up: assert property (p_up) else $error("up");
  c_run: cover property (run_enable_out);
  c_safe: cover property (inhibit_status_out);
  c_mm: cover property (state_out == 2'b10);
endmodule

//--- tb/dti_safety_ctrl.sv
// Safety controller model
`timescale 1ns/1ps
module dti_safety_ctrl (
  input  wire logic [1:0] req_in,
  output logic [1:0] chan_out);
  assign chan_out = req_in;
endmodule

//--- tb/tb_dual_channel_torque_inhibit.sv
// Torque inhibit bench
`timescale 1ns/1ps
module tb_dual_channel_torque_inhibit;
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1;
  logic [1:0] req = 2'b00, ch;
  logic [5:0] got;
  int n_mismatch = 0, checked = 0, seed = 32'hf156;
  always #2.5 ref_clk_in = ~ref_clk_in;
  dti_safety_ctrl u_dti_safety_ctrl (.req_in(req), .chan_out(ch));
  dti_monitor u_dti_monitor (.ref_clk_in, .sys_rst_in, .inhibit_channel_a_in(ch[1]), .inhibit_channel_b_in(ch[0]),
    .run_enable_out(got[3]), .inhibit_trip_out(got[2]), .inhibit_status_out(got[1]),
    .fault_locked_out(got[0]), .state_out(got[5:4]));
  task automatic cmp(input logic [5:0] exp);
    checked++;
    n_mismatch += (got !== exp);
    if (got !== exp) $display("unexpected %0t got %h exp %h", $time, got, exp);
  endtask
  // Lock needs 2.3 s of disagreement, beyond this run, so the model never expects it
  task automatic step(input logic [1:0] r, input int n);
    req <= r;
    repeat (n) @(negedge ref_clk_in);
    cmp(r == 2'b11 ? 6'h18 : r == 2'b00 ? 6'h06 : 6'h24);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial #30_000_000 begin
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (2) @(negedge ref_clk_in);
    cmp(6'h04);
    sys_rst_in <= 1'b0;
    step(2'b11, 8);
    req <= 2'b01;
    repeat (1 + ($random(seed) & 32'h0003_ffff)) @(negedge ref_clk_in);
    step(2'b11, 1);
    step(2'b01, 1_200_000);
    step(2'b00, 1_200_000);
    step(2'b11, 8);
    test_done;
  end
endmodule
bind dti_monitor dti_monitor_checker u_dti_monitor_checker (.*);
